// File: rtl/ssdr_core.sv
// Status, diagnostic and restart logic of the safety sensor
// Notes on behaviour
// - Response byte: outputs on, actuator, inputs live, limit, warning, error.
// - Warning/error bytes flag output faults, cross-wire, temperature; error byte alone flags internal.
// - After power-up outputs off, yellow blinks 5 Hz until release.
// - Auto variant releases on feedback closed; manual ignores it alone.
// - Manual variant releases on reset button falling edge, yellow steady.
// - Only last sensor with chain monitoring checks inputs drop together.
// - Inputs dropping over 500 ms apart: outputs off, discrepancy error.
// - No release while discrepancy error is unacknowledged.
// - Discrepancy error held in non-volatile storage across power loss.
// - Acknowledge button falling edge clears pending discrepancy error.
// - Internal error clears when cause gone and bit7 falls or guard opens.
// - Warning active 30 minutes switches safety outputs off.
// - Link failure leaves safety outputs in their present state.
// - Chain carries up to 31 sensors, each with own bytes.
`timescale 1ns/1ps
`default_nettype none
module ssdr_core
  import ssdr_pkg::*;
#(
  parameter longint BLINK_CYCLES = BLINK_HALF_CYC,
  parameter longint DISC_CYCLES  = DISC_CYC,
  parameter longint WARN_CYCLES  = WARN_CYC,
  parameter longint COMM_CYCLES  = COMM_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire ssdr_pins_t pinIn,
  output logic            safetyOutputA,
  output logic            safetyOutputB,
  output logic            yellowLed,
  output logic            nvDiscStore,
  output ssdr_resp_t      responseStateByte,
  output ssdr_warn_t      warningDetailByte,
  output ssdr_err_t       errorDetailByte
);

  ssdr_pins_t pin;

  ssdr_sync #(
    .W (PINS_W)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .asyncIn  (pinIn),
    .syncOut  (pin)
  );

  // Previous synced levels for edge detection
  ssdr_pins_t   prev_r;
  ssdr_state_t  state_r,     state_nxt;
  logic [1:0]   init_r,      init_nxt;
  logic         disc_r,      disc_nxt;
  logic         intErr_r,    intErr_nxt;
  logic [3:0]   warnLatch_r, warnLatch_nxt;
  logic         commFault_r, commFault_nxt;
  logic [7:0]   reqLast_r,   reqLast_nxt;
  logic         out_r,       out_nxt;
  logic         led_r,       led_nxt;
  logic         blink_r,     blink_nxt;
  logic [CNT_W-1:0] blinkCnt_r, blinkCnt_nxt;
  logic [CNT_W-1:0] discCnt_r,  discCnt_nxt;
  logic [CNT_W-1:0] warnCnt_r,  warnCnt_nxt;
  logic [CNT_W-1:0] commCnt_r,  commCnt_nxt;
  ssdr_resp_t   resp_r,      resp_nxt;
  ssdr_warn_t   warn_r,      warn_nxt;
  ssdr_err_t    err_r,       err_nxt;

  logic strobeRise;
  logic rstBtnFall;
  logic ackBtnFall;
  logic reqRstFall;
  logic reqAckRise;
  logic warnActive;
  logic warnTimeout;
  logic intCause;
  logic guardOpen;
  logic qMonitor;
  logic readyToRelease;
  logic releaseEvent;

  always_comb begin
    strobeRise = pin.reqStrobe & ~prev_r.reqStrobe;
    rstBtnFall = ~pin.resetButton & prev_r.resetButton;
    ackBtnFall = ~pin.ackButton & prev_r.ackButton;
    // Byte settles before the strobe, so compare with the last exchange
    reqRstFall = strobeRise & reqLast_r[REQ_RST_BIT]
                 & ~pin.reqByte[REQ_RST_BIT];
    reqAckRise = strobeRise & pin.reqByte[REQ_ACK_BIT]
                 & ~reqLast_r[REQ_ACK_BIT];
    warnActive = pin.outFaultA | pin.outFaultB | pin.crossWire
                 | pin.overTemp;
    warnTimeout = warnActive && (warnCnt_r >= CNT_W'(WARN_CYCLES));
    intCause   = pin.internalFault | pin.badActuator;
    guardOpen  = ~pin.actuatorDetected;
    qMonitor   = pin.chainMonitorEn & pin.lastInChain;
    readyToRelease = pin.actuatorDetected & pin.safetyInputA
                     & pin.safetyInputB & pin.feedbackClosed
                     & ~disc_r & ~intErr_r & ~warnTimeout;
    // Manual variant needs the monitored button edge
    releaseEvent = pin.manualRelease ? rstBtnFall
                                     : pin.feedbackClosed;
  end

  // Error latches: discrepancy, internal, warning timeout
  always_comb begin
    init_nxt      = init_r;
    disc_nxt      = disc_r;
    intErr_nxt    = intErr_r;
    warnLatch_nxt = warnLatch_r;
    discCnt_nxt   = '0;
    warnCnt_nxt   = '0;
    if (init_r != INIT_DONE) begin
      init_nxt = init_r + 2'h1;
      // Restore after the synchroniser has settled
      if (init_r == INIT_DONE - 2'h1) begin
        disc_nxt = pin.nvDiscRestore;
      end
    end else begin
      // One input low while the other stays high
      if (qMonitor && (pin.safetyInputA != pin.safetyInputB)) begin
        discCnt_nxt = discCnt_r;
        if (discCnt_r < CNT_W'(DISC_CYCLES)) begin
          discCnt_nxt = discCnt_r + CNT_W'(1);
        end
      end
      if (ackBtnFall || reqAckRise) begin
        disc_nxt = 1'b0;
      end
      // Set wins over a simultaneous acknowledge
      if (discCnt_r >= CNT_W'(DISC_CYCLES)) begin
        disc_nxt = 1'b1;
      end
      if (warnActive) begin
        warnCnt_nxt = warnCnt_r;
        if (warnCnt_r < CNT_W'(WARN_CYCLES)) begin
          warnCnt_nxt = warnCnt_r + CNT_W'(1);
        end
      end
      if (!intCause && (reqRstFall || guardOpen)) begin
        intErr_nxt    = 1'b0;
        warnLatch_nxt = '0;
      end
      if (intCause) begin
        intErr_nxt = 1'b1;
      end
      if (warnTimeout) begin
        warnLatch_nxt = {pin.overTemp, pin.crossWire,
                         pin.outFaultB, pin.outFaultA};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_r      <= '0;
      disc_r      <= 1'b0;
      intErr_r    <= 1'b0;
      warnLatch_r <= '0;
      discCnt_r   <= '0;
      warnCnt_r   <= '0;
    end else begin
      init_r      <= init_nxt;
      disc_r      <= disc_nxt;
      intErr_r    <= intErr_nxt;
      warnLatch_r <= warnLatch_nxt;
      discCnt_r   <= discCnt_nxt;
      warnCnt_r   <= warnCnt_nxt;
    end
  end

  // Release state machine and indicator
  always_comb begin
    state_nxt  = state_r;
    blinkCnt_nxt = blinkCnt_r + CNT_W'(1);
    blink_nxt  = blink_r;
    if (blinkCnt_r >= CNT_W'(BLINK_CYCLES - 1)) begin
      blinkCnt_nxt = '0;
      blink_nxt    = ~blink_r;
    end
    unique case (state_r)
      ST_WAIT_RELEASE: begin
        if (intErr_r || warnTimeout) begin
          state_nxt = ST_FAULT;
        end else if (init_r == INIT_DONE && readyToRelease
                     && releaseEvent) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (intErr_r || warnTimeout || disc_r) begin
          state_nxt = ST_FAULT;
        end else if (!pin.actuatorDetected || !pin.safetyInputA
                     || !pin.safetyInputB || !pin.feedbackClosed) begin
          state_nxt = ST_WAIT_RELEASE;
        end
      end
      ST_FAULT: begin
        if (!intErr_r && !warnTimeout && !disc_r) begin
          state_nxt = ST_WAIT_RELEASE;
        end
      end
    endcase
    // Link state plays no part here, so a lost link holds the outputs
    out_nxt = (state_nxt == ST_ACTIVE);
    // Steady in active, blinking while waiting, dark on fault
    led_nxt = 1'b0;
    unique case (state_nxt)
      ST_WAIT_RELEASE: led_nxt = blink_nxt;
      ST_ACTIVE:       led_nxt = 1'b1;
      ST_FAULT:        led_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= ST_WAIT_RELEASE;
      blinkCnt_r <= '0;
      blink_r    <= 1'b0;
      out_r      <= 1'b0;
      led_r      <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      blinkCnt_r <= blinkCnt_nxt;
      blink_r    <= blink_nxt;
      out_r      <= out_nxt;
      led_r      <= led_nxt;
    end
  end

  // Serial diagnostic exchange: snapshot on every request strobe
  always_comb begin
    reqLast_nxt   = reqLast_r;
    commCnt_nxt   = commCnt_r;
    commFault_nxt = commFault_r;
    resp_nxt      = resp_r;
    warn_nxt      = warn_r;
    err_nxt       = err_r;
    if (strobeRise) begin
      reqLast_nxt   = pin.reqByte;
      commCnt_nxt   = '0;
      commFault_nxt = 1'b0;
    end else if (commCnt_r >= CNT_W'(COMM_CYCLES)) begin
      commFault_nxt = 1'b1;
    end else begin
      commCnt_nxt = commCnt_r + CNT_W'(1);
    end
    if (strobeRise) begin
      resp_nxt.outputsOn      = out_r;
      resp_nxt.actuatorSeen   = pin.actuatorDetected;
      resp_nxt.rsvd2          = 1'b0;
      resp_nxt.releasePending = pin.actuatorDetected
                                & (state_r == ST_WAIT_RELEASE);
      resp_nxt.inputsLive     = pin.safetyInputA & pin.safetyInputB;
      resp_nxt.limitArea      = pin.limitArea;
      resp_nxt.warning        = warnActive | commFault_r;
      resp_nxt.errorOff       = (state_r == ST_FAULT);
      warn_nxt.outFaultA      = pin.outFaultA;
      warn_nxt.outFaultB      = pin.outFaultB;
      warn_nxt.crossWire      = pin.crossWire;
      warn_nxt.overTemp       = pin.overTemp;
      warn_nxt.rsvd4          = 1'b0;
      warn_nxt.internalFault  = 1'b0;
      warn_nxt.commFault      = commFault_r;
      warn_nxt.rsvd7          = 1'b0;
      err_nxt.outFaultA       = warnLatch_r[0];
      err_nxt.outFaultB       = warnLatch_r[1];
      err_nxt.crossWire       = warnLatch_r[2];
      err_nxt.overTemp        = warnLatch_r[3];
      err_nxt.badActuator     = pin.badActuator;
      err_nxt.internalFault   = intErr_r;
      err_nxt.discrepancy     = disc_r;
      err_nxt.rsvd7           = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r      <= '0;
      reqLast_r   <= '0;
      commCnt_r   <= '0;
      commFault_r <= 1'b0;
      resp_r      <= '0;
      warn_r      <= '0;
      err_r       <= '0;
    end else begin
      prev_r      <= pin;
      reqLast_r   <= reqLast_nxt;
      commCnt_r   <= commCnt_nxt;
      commFault_r <= commFault_nxt;
      resp_r      <= resp_nxt;
      warn_r      <= warn_nxt;
      err_r       <= err_nxt;
    end
  end

  assign safetyOutputA     = out_r;
  assign safetyOutputB     = out_r;
  assign yellowLed         = led_r;
  // Storage mirrors the latch so a power cut keeps the error
  assign nvDiscStore       = disc_r;
  assign responseStateByte = resp_r;
  assign warningDetailByte = warn_r;
  assign errorDetailByte   = err_r;

endmodule
`default_nettype wire

// File: rtl/ssdr_pkg.sv
// Shared types and constants of the safety sensor diagnostic and restart block
package ssdr_pkg;

  localparam longint CLK_HZ          = 100_000_000;
  localparam longint CYC_PER_MS      = CLK_HZ / 1000;
  // Yellow indicator blink at 5 Hz: 100 ms per half period
  localparam longint BLINK_HZ        = 5;
  localparam longint BLINK_HALF_CYC  = CLK_HZ / (2 * BLINK_HZ);
  localparam longint DISC_MS         = 500;
  localparam longint DISC_CYC        = DISC_MS * CYC_PER_MS;
  localparam longint WARN_MIN        = 30;
  localparam longint WARN_CYC        = WARN_MIN * 60 * CLK_HZ;
  localparam longint COMM_MS         = 100;
  localparam longint COMM_CYC        = COMM_MS * CYC_PER_MS;
  localparam int     CNT_W           = 38;
  localparam int     SYNC_STAGES     = 2;
  localparam logic [1:0] INIT_DONE   = 2'h3;
  localparam int     CHAIN_MAX       = 31;

  // Request byte bit positions
  localparam int REQ_ACK_BIT = 6;
  localparam int REQ_RST_BIT = 7;

  // Response byte
  typedef struct packed {
    logic errorOff;
    logic warning;
    logic limitArea;
    logic inputsLive;
    logic releasePending;
    logic rsvd2;
    logic actuatorSeen;
    logic outputsOn;
  } ssdr_resp_t;

  // Warning byte
  typedef struct packed {
    logic rsvd7;
    logic commFault;
    logic internalFault;
    logic rsvd4;
    logic overTemp;
    logic crossWire;
    logic outFaultB;
    logic outFaultA;
  } ssdr_warn_t;

  // Error byte
  typedef struct packed {
    logic rsvd7;
    logic discrepancy;
    logic internalFault;
    logic badActuator;
    logic overTemp;
    logic crossWire;
    logic outFaultB;
    logic outFaultA;
  } ssdr_err_t;

  // Every pin the sensor core samples; all asynchronous to core_clk
  typedef struct packed {
    logic       reqStrobe;
    logic [7:0] reqByte;
    logic       safetyInputA;
    logic       safetyInputB;
    logic       actuatorDetected;
    logic       limitArea;
    logic       feedbackClosed;
    logic       resetButton;
    logic       ackButton;
    logic       manualRelease;
    logic       chainMonitorEn;
    logic       lastInChain;
    logic       outFaultA;
    logic       outFaultB;
    logic       crossWire;
    logic       overTemp;
    logic       badActuator;
    logic       internalFault;
    logic       nvDiscRestore;
  } ssdr_pins_t;

  localparam int PINS_W = $bits(ssdr_pins_t);

  typedef enum logic [1:0] {
    ST_WAIT_RELEASE,
    ST_ACTIVE,
    ST_FAULT
  } ssdr_state_t;

endpackage

// File: rtl/ssdr_sync.sv
// Two-stage synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module ssdr_sync
  import ssdr_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = asyncIn;
    sync_nxt = meta_r;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign syncOut = sync_r;

endmodule
`default_nettype wire

// File: tb/ssdr_gateway_model.sv
// Gateway model: periodic exchanges on the serial diagnostic link
`timescale 1ns/1ps
`default_nettype none
module ssdr_gateway_model (
  input  wire logic       core_clk,
  input  wire logic       linkOn,
  input  wire logic [7:0] reqIn,
  output logic            reqStrobe,
  output logic [7:0]      reqByte
);
  int phase = 0;
  // Byte settles three cycles ahead of the strobe rise
  always @(negedge core_clk) begin
    phase <= (phase + 1) % 6;
    if (phase == 0) reqByte <= reqIn;
    reqStrobe <= linkOn && (phase >= 3);
  end
endmodule
`default_nettype wire

// File: tb/ssdr_monitor.sv
// Concurrent checks on the ports of the sensor core
`timescale 1ns/1ps
`default_nettype none
module ssdr_monitor
  import ssdr_pkg::*;
#(
  parameter longint BLINK_CYCLES = BLINK_HALF_CYC,
  parameter longint DISC_CYCLES  = DISC_CYC
) (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire ssdr_pins_t pinIn,
  input wire logic       safetyOutputA,
  input wire logic       safetyOutputB,
  input wire logic       yellowLed,
  input wire logic       nvDiscStore,
  input wire ssdr_resp_t responseStateByte
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  longint ledRun_r;
  longint ledRun_nxt;
  longint diffRun_r;
  longint diffRun_nxt;
  always_comb begin
    ledRun_nxt  = yellowLed ? ledRun_r + 1 : 0;
    diffRun_nxt = (pinIn.safetyInputA != pinIn.safetyInputB) ?
                  diffRun_r + 1 : 0;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ledRun_r  <= 0;
      diffRun_r <= 0;
    end else begin
      ledRun_r  <= ledRun_nxt;
      diffRun_r <= diffRun_nxt;
    end
  end
  outs_equal_a: assert property (safetyOutputA == safetyOutputB)
    else $error("safety outputs differ");
  blink_period_a: assert property ($fell(yellowLed) && !safetyOutputA
    |-> ledRun_r >= BLINK_CYCLES) else $error("blink phase too short");
  led_on_a: assert property ($rose(safetyOutputA) && !pinIn.limitArea
    |-> ##[0:2] yellowLed) else $error("yellow not lit on release");
  auto_release_a: assert property ($rose(safetyOutputA)
    && !pinIn.manualRelease |-> $past(pinIn.feedbackClosed, 3)
    && $past(pinIn.actuatorDetected, 3)) else $error("auto release cause");
  manual_release_a: assert property ($rose(safetyOutputA)
    && pinIn.manualRelease |-> $past(pinIn.resetButton, 8)
    && !$past(pinIn.resetButton, 2)) else $error("manual release cause");
  disc_off_a: assert property ($rose(nvDiscStore)
    |-> ##[0:2] !safetyOutputA) else $error("outputs on after discrepancy");
  disc_cause_a: assert property ($rose(nvDiscStore)
    && !pinIn.nvDiscRestore |-> diffRun_r >= DISC_CYCLES
    && pinIn.chainMonitorEn && pinIn.lastInChain)
    else $error("discrepancy without cause");
  disc_block_a: assert property ($rose(safetyOutputA)
    |-> !$past(nvDiscStore)) else $error("release while discrepancy");
  bytes_refresh_a: assert property ($changed(responseStateByte)
    |-> $past(pinIn.reqStrobe, 2)) else $error("bytes moved off exchange");
endmodule
bind ssdr_core ssdr_monitor #(
  .BLINK_CYCLES(BLINK_CYCLES),
  .DISC_CYCLES (DISC_CYCLES)
) ssdr_monitor_inst (.core_clk, .rst_n, .pinIn, .safetyOutputA,
  .safetyOutputB, .yellowLed, .nvDiscStore, .responseStateByte);
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the sensor core
`timescale 1ns/1ps
`default_nettype none
module tb
  import ssdr_pkg::*;
();
  logic        core_clk;
  logic        rst_n;
  logic        linkOn;
  logic        gwStrobe;
  logic [7:0]  reqIn;
  logic [7:0]  gwByte;
  logic [31:0] seed = 32'hb504;
  logic [31:0] w;
  int          error_cnt = 0;
  int          comparisons = 0;
  ssdr_pins_t  pins;
  ssdr_pins_t  pinIn;
  logic        safetyOutputA;
  logic        safetyOutputB;
  logic        yellowLed;
  logic        nvDiscStore;
  ssdr_resp_t  responseStateByte;
  ssdr_warn_t  warningDetailByte;
  ssdr_err_t   errorDetailByte;
  always_comb begin
    pinIn           = pins;
    pinIn.reqStrobe = gwStrobe;
    pinIn.reqByte   = gwByte;
  end
  // Short counts keep the run brief
  ssdr_core #(.BLINK_CYCLES(8), .DISC_CYCLES(20), .WARN_CYCLES(50),
    .COMM_CYCLES(40)) ssdr_core_inst (.core_clk, .rst_n, .pinIn,
    .safetyOutputA, .safetyOutputB, .yellowLed, .nvDiscStore,
    .responseStateByte, .warningDetailByte, .errorDetailByte);
  ssdr_gateway_model ssdr_gateway_model_inst (.core_clk, .linkOn, .reqIn,
    .reqStrobe(gwStrobe), .reqByte(gwByte));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] expResp(input logic on);
    return {1'b0, pins.outFaultA | pins.outFaultB | pins.crossWire |
      pins.overTemp, pins.limitArea, pins.safetyInputA & pins.safetyInputB,
      !on & pins.actuatorDetected, 1'b0, pins.actuatorDetected, on};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string nm);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wait_out(input logic v);
    int i;
    for (i = 0; i < 40 && safetyOutputA !== v; i++) tick(1);
    if (safetyOutputA !== v) begin
      error_cnt++;
      $display("MISMATCH outA wait expected %h seen %h", v, safetyOutputA);
      end_sim();
    end
  endtask
  task automatic do_reset(input logic restore);
    rst_n = 1'b0;
    pins = '0;
    pins.nvDiscRestore = restore;
    reqIn = 8'h00;
    linkOn = 1'b1;
    tick(8);
    rst_n = 1'b1;
    tick(8);
  endtask
  task automatic go_auto();
    {pins.safetyInputA, pins.safetyInputB, pins.actuatorDetected} = 3'h7;
    tick(20);
    chk(safetyOutputA, 1'b0, "outA open loop");
    chk(responseStateByte, expResp(1'b0), "response wait");
    pins.feedbackClosed = 1'b1;
    wait_out(1'b1);
  endtask
  initial begin
    int tog;
    int k;
    do_reset(1'b0);
    tog = 0;
    for (k = 0; k < 32; k++) begin
      w[0] = yellowLed;
      tick(1);
      tog += (yellowLed !== w[0]);
    end
    chk(8'(tog), 8'h04, "blink toggles");
    go_auto();
    chk(yellowLed, 1'b1, "yellow steady");
    for (k = 0; k < 4; k++) begin
      w = rnd();
      {pins.overTemp, pins.crossWire, pins.outFaultB, pins.outFaultA,
        pins.limitArea} = w[4:0];
      tick(15);
      chk(warningDetailByte[3:0], w[4:1], "warn causes");
      chk(responseStateByte, expResp(1'b1), "response");
      {pins.overTemp, pins.crossWire, pins.outFaultB, pins.outFaultA,
        pins.limitArea} = 5'h00;
      tick(15);
    end
    linkOn = 1'b0;
    tick(60);
    chk(safetyOutputA, 1'b1, "outA link lost");
    linkOn = 1'b1;
    for (k = 0; k < 12 && warningDetailByte.commFault !== 1'b1; k++) tick(1);
    chk(warningDetailByte.commFault, 1'b1, "warn link");
    if (warningDetailByte.commFault !== 1'b1) end_sim();
    pins.overTemp = 1'b1;
    tick(70);
    chk(safetyOutputA, 1'b0, "outA warn timeout");
    chk(errorDetailByte.overTemp, 1'b1, "err temp");
    do_reset(1'b0);
    go_auto();
    pins.internalFault = 1'b1;
    wait_out(1'b0);
    tick(15);
    chk(errorDetailByte.internalFault, 1'b1, "err internal");
    chk(responseStateByte.errorOff, 1'b1, "resp error");
    pins.internalFault = 1'b0;
    reqIn = 8'h80;
    tick(15);
    reqIn = 8'h00;
    tick(30);
    chk(errorDetailByte.internalFault, 1'b0, "err cleared");
    pins.badActuator = 1'b1;
    tick(15);
    chk(errorDetailByte.badActuator, 1'b1, "err actuator");
    do_reset(1'b0);
    go_auto();
    pins.chainMonitorEn = 1'b1;
    pins.safetyInputA = 1'b0;
    tick(40);
    chk(nvDiscStore, 1'b0, "disc not last");
    pins.lastInChain = 1'b1;
    tick(40);
    chk(nvDiscStore, 1'b1, "disc latched");
    chk(safetyOutputA, 1'b0, "outA disc");
    chk(errorDetailByte.discrepancy, 1'b1, "err disc");
    pins.safetyInputA = 1'b1;
    tick(30);
    chk(safetyOutputA, 1'b0, "outA held off");
    pins.ackButton = 1'b1;
    tick(5);
    pins.ackButton = 1'b0;
    tick(6);
    chk(nvDiscStore, 1'b0, "disc ack button");
    do_reset(1'b1);
    chk(nvDiscStore, 1'b1, "disc restored");
    {pins.safetyInputA, pins.safetyInputB, pins.actuatorDetected} = 3'h7;
    pins.feedbackClosed = 1'b1;
    tick(30);
    chk(safetyOutputA, 1'b0, "outA restored off");
    reqIn = 8'h40;
    tick(15);
    chk(nvDiscStore, 1'b0, "disc ack serial");
    do_reset(1'b0);
    pins.manualRelease = 1'b1;
    {pins.safetyInputA, pins.safetyInputB, pins.actuatorDetected,
      pins.feedbackClosed} = 4'hf;
    tick(30);
    chk(safetyOutputA, 1'b0, "outA manual loop");
    pins.resetButton = 1'b1;
    tick(6);
    pins.resetButton = 1'b0;
    wait_out(1'b1);
    chk(yellowLed, 1'b1, "yellow manual");
    end_sim();
  end
endmodule
`default_nettype wire
